// ==== pkg/mcd_pkg.sv ====
/*
  Shared constants and types for the multiphase clock divider: settings encodings,
  divide factors, phase step counts, spread sequence sizes and the phase output bundle.
  Assumes nothing beyond a SystemVerilog tool; every user writes mcd_pkg::name.
*/
package mcd_pkg;

  // ****************************************************************
  // Clock relation and divide factors
  // ****************************************************************
  // The logic clock runs at twice the master oscillator rate, so a step of
  // the phase generator is half a divided master period.
  localparam int CLKS_PER_MASTER   = 2;
  localparam int DIV_FACTOR_ONE     = 1;
  localparam int DIV_FACTOR_TEN     = 10;
  localparam int DIV_FACTOR_HUNDRED = 100;
  localparam int DIV_CNT_WIDTH      = 7;

  // ****************************************************************
  // Phase generator step counts (steps are half divided periods)
  // ****************************************************************
  localparam int STEP_WIDTH        = 3;
  localparam logic [2:0] STEPS_TWO   = 3'h2;
  localparam logic [2:0] STEPS_THREE = 3'h6;
  localparam logic [3:0] STEPS_FOUR  = 4'h8;
  localparam logic [2:0] STEP_LAST_FOUR = 3'h7;
  localparam logic [2:0] THIRD_STEPS   = 3'h2;
  localparam logic [2:0] QUARTER_STEPS = 3'h2;
  localparam logic [2:0] HALF_STEPS    = 3'h4;
  localparam logic [2:0] STEP_ZERO     = 3'h0;

  // ****************************************************************
  // Spread spectrum sequence
  // ****************************************************************
  localparam int SPREAD_MASTER_DIV = 3200;
  localparam int SPREAD_CNT_WIDTH  = 13;
  localparam int LFSR_WIDTH        = 9;
  localparam int CODE_WIDTH        = 7;
  localparam int LFSR_TAP_HI       = 8;
  localparam int LFSR_TAP_LO       = 4;
  localparam logic [8:0] LFSR_SEED = 9'h000;
  localparam logic [6:0] CODE_NOMINAL = 7'h00;

  // ****************************************************************
  // Settings encodings
  // ****************************************************************
  // Three-level pin as a two-bit code; 2'b11 is taken as open.
  localparam logic [1:0] LEVEL_LOW  = 2'h0;
  localparam logic [1:0] LEVEL_OPEN = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  typedef enum logic [1:0] {
    MCD_PHASES_TWO   = 2'b00,
    MCD_PHASES_THREE = 2'b01,
    MCD_PHASES_FOUR  = 2'b10
  } mcd_phase_mode_type;

  typedef enum logic [0:0] {
    MCD_ST_RESTART = 1'b0,
    MCD_ST_RUN     = 1'b1
  } mcd_run_state_type;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } mcd_phase_type;

endpackage

// ==== src/mcd_multiphase_divider.sv ====
/*
  Digital core of a resistor-set multiphase oscillator: programmable divider,
  2/3/4-phase generator and the spread spectrum modulation code source.
  Assumes I_CLOCK is the only clock and runs at twice the master oscillator
  rate; the settings arrive as static two-bit level codes synchronous to it.
*/
// How it works
// - Divider divides master clock by 1, 10, 100.
// - Divide select low passes master clock straight.
// - Divide select open or mid divides by ten.
// - Divide select high divides by one hundred.
// - Phase select low gives two phases, M=1.
// - Phase select open gives three phases, M=3.
// - Phase select high gives four phases, M=4.
// - Divided clock drives four phase output lines.
// - Three and four phase divide further.
// - Phase mode sets each output duty cycle.
// - Spread control low stops and clears modulation.
// - Spreading only ever lowers the frequency.
// - Code zero means nominal, the upper bound.
// - Two-phase: complementary halves, c and d copy.
// - Three-phase: thirds lagging 120 degrees, d low.
// - Four-phase: halves lagging a quarter period each.
// - Nine-bit sequence steps every 3200 master cycles.
`timescale 1ns/1ps

module mcd_multiphase_divider #(
  parameter int SPREAD_STEP_CYCLES = mcd_pkg::SPREAD_MASTER_DIV * mcd_pkg::CLKS_PER_MASTER
) (
  input  wire logic                           I_CLOCK,
  input  wire logic                           I_RST,
  input  wire logic [1:0]                     I_DIVIDE_SELECT,
  input  wire logic [1:0]                     I_PHASE_SELECT,
  input  wire logic                           I_SPREAD_CONTROL,
  output logic                                O_PHASE_OUT_A,
  output logic                                O_PHASE_OUT_B,
  output logic                                O_PHASE_OUT_C,
  output logic                                O_PHASE_OUT_D,
  output logic [mcd_pkg::CODE_WIDTH-1:0]      O_SPREAD_CODE,
  output logic                                O_SPREAD_ACTIVE
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // divide factor decode
  function automatic logic [mcd_pkg::DIV_CNT_WIDTH-1:0] div_factor(input logic [1:0] level);
    logic [mcd_pkg::DIV_CNT_WIDTH-1:0] factor;
    case (level)
      mcd_pkg::LEVEL_LOW:  factor = mcd_pkg::DIV_CNT_WIDTH'(mcd_pkg::DIV_FACTOR_ONE);
      mcd_pkg::LEVEL_HIGH: factor = mcd_pkg::DIV_CNT_WIDTH'(mcd_pkg::DIV_FACTOR_HUNDRED);
      default:             factor = mcd_pkg::DIV_CNT_WIDTH'(mcd_pkg::DIV_FACTOR_TEN);
    endcase
    return factor;
  endfunction

  function automatic mcd_pkg::mcd_phase_mode_type phase_mode(input logic [1:0] level);
    mcd_pkg::mcd_phase_mode_type mode;
    case (level)
      mcd_pkg::LEVEL_LOW:  mode = mcd_pkg::MCD_PHASES_TWO;
      mcd_pkg::LEVEL_HIGH: mode = mcd_pkg::MCD_PHASES_FOUR;
      default:             mode = mcd_pkg::MCD_PHASES_THREE;
    endcase
    return mode;
  endfunction

  function automatic logic [mcd_pkg::STEP_WIDTH-1:0] last_step(
    input mcd_pkg::mcd_phase_mode_type mode);
    logic [mcd_pkg::STEP_WIDTH-1:0] last;
    case (mode)
      mcd_pkg::MCD_PHASES_TWO:   last = mcd_pkg::STEPS_TWO - 3'h1;
      mcd_pkg::MCD_PHASES_THREE: last = mcd_pkg::STEPS_THREE - 3'h1;
      default:               last = mcd_pkg::STEP_LAST_FOUR;
    endcase
    return last;
  endfunction

  function automatic mcd_pkg::mcd_phase_type phase_pattern(
    input mcd_pkg::mcd_phase_mode_type mode, input logic [mcd_pkg::STEP_WIDTH-1:0] step);
    mcd_pkg::mcd_phase_type pat;
    pat = '0;
    case (mode)
      mcd_pkg::MCD_PHASES_TWO: begin
        pat.a = (step == mcd_pkg::STEP_ZERO);
        pat.b = ~pat.a;
        pat.c = pat.a;
        pat.d = pat.b;
      end
      mcd_pkg::MCD_PHASES_THREE: begin
        pat.a = (step < mcd_pkg::THIRD_STEPS);
        pat.b = (step >= mcd_pkg::THIRD_STEPS) && (step < 2 * mcd_pkg::THIRD_STEPS);
        pat.c = (step >= 2 * mcd_pkg::THIRD_STEPS);
        pat.d = 1'b0;
      end
      mcd_pkg::MCD_PHASES_FOUR: begin
        pat.a = (step < mcd_pkg::HALF_STEPS);
        pat.b = (step >= mcd_pkg::QUARTER_STEPS)
                && (step < mcd_pkg::QUARTER_STEPS + mcd_pkg::HALF_STEPS);
        pat.c = (step >= mcd_pkg::HALF_STEPS);
        pat.d = (step >= mcd_pkg::QUARTER_STEPS + mcd_pkg::HALF_STEPS)
                || (step < mcd_pkg::QUARTER_STEPS);
      end
      default: pat = '0;
    endcase
    return pat;
  endfunction

  // ****************************************************************
  // Settings and run state
  // ****************************************************************
  localparam int SPREAD_LAST = SPREAD_STEP_CYCLES - 1;

  mcd_pkg::mcd_run_state_type          state_ff;
  mcd_pkg::mcd_run_state_type          nxt_state;
  logic [mcd_pkg::DIV_CNT_WIDTH-1:0]   factor_ff;
  logic [mcd_pkg::DIV_CNT_WIDTH-1:0]   nxt_factor;
  mcd_pkg::mcd_phase_mode_type         mode_ff;
  mcd_pkg::mcd_phase_mode_type         nxt_mode;
  logic                                settings_changed;

  always_comb begin
    nxt_factor       = div_factor(I_DIVIDE_SELECT);
    nxt_mode         = phase_mode(I_PHASE_SELECT);
    settings_changed = (nxt_factor != factor_ff) || (nxt_mode != mode_ff);
    case (state_ff)
      mcd_pkg::MCD_ST_RESTART: nxt_state = mcd_pkg::MCD_ST_RUN;
      mcd_pkg::MCD_ST_RUN:     nxt_state = settings_changed ? mcd_pkg::MCD_ST_RESTART
                                                            : mcd_pkg::MCD_ST_RUN;
      default:                 nxt_state = mcd_pkg::MCD_ST_RESTART;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state_ff  <= mcd_pkg::MCD_ST_RESTART;
      factor_ff <= mcd_pkg::DIV_CNT_WIDTH'(mcd_pkg::DIV_FACTOR_TEN);
      mode_ff   <= mcd_pkg::MCD_PHASES_THREE;
    end else begin
      state_ff  <= nxt_state;
      factor_ff <= nxt_factor;
      mode_ff   <= nxt_mode;
    end
  end

  // ****************************************************************
  // Divider and phase generator
  // ****************************************************************
  // A settings change restarts both counters so that a new mode never runs
  // with a step count left over from the old one.
  logic [mcd_pkg::DIV_CNT_WIDTH-1:0]   div_cnt_ff;
  logic [mcd_pkg::DIV_CNT_WIDTH-1:0]   nxt_div_cnt;
  logic [mcd_pkg::STEP_WIDTH-1:0]      step_ff;
  logic [mcd_pkg::STEP_WIDTH-1:0]      nxt_step;
  mcd_pkg::mcd_phase_type              phase_ff;
  mcd_pkg::mcd_phase_type              nxt_phase;
  logic                                div_tick;

  always_comb begin
    div_tick    = (div_cnt_ff == factor_ff - 7'h01);
    nxt_div_cnt = div_tick ? '0 : div_cnt_ff + 7'h01;
    nxt_step    = step_ff;
    if (div_tick) begin
      nxt_step = (step_ff == last_step(mode_ff)) ? mcd_pkg::STEP_ZERO : step_ff + 3'h1;
    end
    if (state_ff == mcd_pkg::MCD_ST_RESTART || settings_changed) begin
      nxt_div_cnt = '0;
      nxt_step    = mcd_pkg::STEP_ZERO;
    end
    nxt_phase = phase_pattern(settings_changed ? nxt_mode : mode_ff, nxt_step);
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      div_cnt_ff <= '0;
      step_ff    <= mcd_pkg::STEP_ZERO;
      phase_ff   <= '0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      step_ff    <= nxt_step;
      phase_ff   <= nxt_phase;
    end
  end

  assign O_PHASE_OUT_A = phase_ff.a;
  assign O_PHASE_OUT_B = phase_ff.b;
  assign O_PHASE_OUT_C = phase_ff.c;
  assign O_PHASE_OUT_D = phase_ff.d;

  // ****************************************************************
  // Spread spectrum code
  // ****************************************************************
  // The code is the amount of downward pull on the oscillator current; zero
  // leaves the oscillator at its nominal rate, so no code can raise it.
  logic [mcd_pkg::SPREAD_CNT_WIDTH-1:0] spread_cnt_ff;
  logic [mcd_pkg::SPREAD_CNT_WIDTH-1:0] nxt_spread_cnt;
  logic [mcd_pkg::CODE_WIDTH-1:0]       code_ff;
  logic [mcd_pkg::CODE_WIDTH-1:0]       nxt_code;
  logic                                 active_ff;
  logic                                 spread_step;
  logic [mcd_pkg::LFSR_WIDTH-1:0]       lfsr_state;

  always_comb begin
    spread_step    = I_SPREAD_CONTROL
                     && (spread_cnt_ff == mcd_pkg::SPREAD_CNT_WIDTH'(SPREAD_LAST));
    nxt_spread_cnt = spread_step ? '0 : spread_cnt_ff + 13'h0001;
    nxt_code       = lfsr_state[mcd_pkg::CODE_WIDTH-1:0];
    if (!I_SPREAD_CONTROL) begin
      nxt_spread_cnt = '0;
      nxt_code       = mcd_pkg::CODE_NOMINAL;
    end
  end

  mcd_spread_lfsr #(
    .WIDTH (mcd_pkg::LFSR_WIDTH)
  ) mcd_spread_lfsr_inst (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_clear (~I_SPREAD_CONTROL),
    .i_step  (spread_step),
    .o_state (lfsr_state)
  );

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      spread_cnt_ff <= '0;
      code_ff       <= mcd_pkg::CODE_NOMINAL;
      active_ff     <= 1'b0;
    end else begin
      spread_cnt_ff <= nxt_spread_cnt;
      code_ff       <= nxt_code;
      active_ff     <= I_SPREAD_CONTROL;
    end
  end

  assign O_SPREAD_CODE   = code_ff;
  assign O_SPREAD_ACTIVE = active_ff;

endmodule // mcd_multiphase_divider

// ==== src/mcd_spread_lfsr.sv ====
/*
  Nine-bit pseudorandom sequence generator for frequency spreading.
  Assumes a single clock, an asynchronous active-high reset and a step strobe
  from the owner; a clear holds it at the seed while spreading is off.
*/
`timescale 1ns/1ps

module mcd_spread_lfsr #(
  parameter int WIDTH = mcd_pkg::LFSR_WIDTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_clear,
  input  wire logic             i_step,
  output logic      [WIDTH-1:0] o_state
);

  logic [WIDTH-1:0] lfsr_ff;
  logic [WIDTH-1:0] nxt_lfsr;
  logic             feedback;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // The zero-detect term splices the all-zero state into the maximal cycle,
  // so the sequence covers every one of its 2**WIDTH states.
  always_comb begin
    feedback = lfsr_ff[mcd_pkg::LFSR_TAP_HI] ^ lfsr_ff[mcd_pkg::LFSR_TAP_LO]
               ^ (lfsr_ff[WIDTH-2:0] == '0);
    nxt_lfsr = lfsr_ff;
    if (i_clear) begin
      nxt_lfsr = mcd_pkg::LFSR_SEED;
    end else if (i_step) begin
      nxt_lfsr = {lfsr_ff[WIDTH-2:0], feedback};
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lfsr_ff <= mcd_pkg::LFSR_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  assign o_state = lfsr_ff;

endmodule // mcd_spread_lfsr

// ==== testbench/mcd_load_model.sv ====
/*
  Clocked load on the four phase lines: measures period, high times and lag in clocks.
  Assumes it samples on the same rising edge that launches the phase outputs.
*/
`timescale 1ns/1ps

module mcd_load_model (
  input  wire logic                   i_clock,
  input  wire logic                   i_clear,
  input  wire mcd_pkg::mcd_phase_type i_phase,
  output logic [15:0]                 o_period,
  output logic [15:0]                 o_high_a,
  output logic [15:0]                 o_lag_b,
  output logic [15:0]                 o_high_d
);
  logic [15:0]            tick, rise_a, rise_d;
  mcd_pkg::mcd_phase_type last;
  // Only whole periods after a clear count, so the first partial figures are overwritten.
  always @(posedge i_clock) begin
    if (i_clear) begin
      {tick, rise_a, rise_d} = 48'h0;
      {o_period, o_high_a, o_lag_b, o_high_d} = 64'h0;
    end else begin
      tick = tick + 16'h1;
      if (i_phase.a && !last.a) begin
        o_period = tick - rise_a;
        rise_a = tick;
      end
      if (!i_phase.a && last.a) o_high_a = tick - rise_a;
      if (i_phase.b && !last.b) o_lag_b = tick - rise_a;
      if (i_phase.d && !last.d) rise_d = tick;
      if (!i_phase.d && last.d) o_high_d = tick - rise_d;
    end
    last = i_phase;
  end
endmodule // mcd_load_model

// ==== testbench/mcd_multiphase_divider_properties.sv ====
/*
  Port checker for the multiphase divider: phase patterns, divide timing and spread code.
  Assumes a bind to the top module, handing on the spread step parameter.
*/
`timescale 1ns/1ps

module mcd_multiphase_divider_properties #(
  parameter int SPREAD_STEP_CYCLES = 6400
) (
  input wire logic                          I_CLOCK,
  input wire logic                          I_RST,
  input wire logic [1:0]                    I_DIVIDE_SELECT,
  input wire logic [1:0]                    I_PHASE_SELECT,
  input wire logic                          I_SPREAD_CONTROL,
  input wire logic                          O_PHASE_OUT_A,
  input wire logic                          O_PHASE_OUT_B,
  input wire logic                          O_PHASE_OUT_C,
  input wire logic                          O_PHASE_OUT_D,
  input wire logic [mcd_pkg::CODE_WIDTH-1:0] O_SPREAD_CODE,
  input wire logic                          O_SPREAD_ACTIVE
);
  // ****************************************************************
  // Settings history
  // ****************************************************************
  // The outputs reflect the settings of one edge back, so the checks decode sel_ff.
  logic [3:0] sel_ff, nxt_sel, settle_ff, nxt_settle;
  logic       live_ff, nxt_live;
  always_comb begin
    nxt_sel    = {I_DIVIDE_SELECT, I_PHASE_SELECT};
    nxt_live   = 1'b1;
    nxt_settle = (nxt_sel != sel_ff) ? 4'h0 : settle_ff + {3'h0, settle_ff != 4'hf};
  end
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      sel_ff    <= 4'h0;
      settle_ff <= 4'h0;
      live_ff   <= 1'b0;
    end else begin
      sel_ff    <= nxt_sel;
      settle_ff <= nxt_settle;
      live_ff   <= nxt_live;
    end
  end
  default clocking dclk @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_reset_quiet;
    disable iff (1'b0) I_RST |-> {O_PHASE_OUT_A, O_PHASE_OUT_B, O_PHASE_OUT_C, O_PHASE_OUT_D,
      O_SPREAD_CODE, O_SPREAD_ACTIVE} == 12'h000;
  endproperty
  property p_two_phase;
    live_ff && sel_ff[1:0] == 2'h0 |-> O_PHASE_OUT_B == !O_PHASE_OUT_A
      && O_PHASE_OUT_C == O_PHASE_OUT_A && O_PHASE_OUT_D == O_PHASE_OUT_B;
  endproperty
  property p_three_phase;
    live_ff && sel_ff[0] |-> $onehot({O_PHASE_OUT_A, O_PHASE_OUT_B, O_PHASE_OUT_C})
      && !O_PHASE_OUT_D;
  endproperty
  property p_four_phase;
    live_ff && sel_ff[1:0] == 2'h2 |-> $countones({O_PHASE_OUT_A, O_PHASE_OUT_B, O_PHASE_OUT_C,
      O_PHASE_OUT_D}) == 2 && O_PHASE_OUT_A != O_PHASE_OUT_C && O_PHASE_OUT_B != O_PHASE_OUT_D;
  endproperty
  property p_div1_toggle;
    settle_ff > 4'h5 && sel_ff == 4'h0 |-> O_PHASE_OUT_A != $past(O_PHASE_OUT_A);
  endproperty
  property p_div10_high;
    disable iff (I_RST || settle_ff == 4'h0) settle_ff > 4'h5 && sel_ff == 4'h4
      && $rose(O_PHASE_OUT_A) |-> O_PHASE_OUT_A[*8] ##1 O_PHASE_OUT_A[*2] ##1 !O_PHASE_OUT_A;
  endproperty
  property p_code_off;
    !$past(I_SPREAD_CONTROL) && !$past(I_SPREAD_CONTROL, 2) |-> O_SPREAD_CODE == 7'h00;
  endproperty
  property p_active_copy;
    live_ff |-> O_SPREAD_ACTIVE == $past(I_SPREAD_CONTROL);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet in reset");
  a_two_phase: assert property (p_two_phase) else $error("two-phase relation broken");
  a_three_phase: assert property (p_three_phase) else $error("three-phase pattern broken");
  a_four_phase: assert property (p_four_phase) else $error("four-phase pattern broken");
  a_div1_toggle: assert property (p_div1_toggle) else $error("divide by one not toggling");
  a_div10_high: assert property (p_div10_high) else $error("divide by ten half period");
  a_code_off: assert property (p_code_off) else $error("spread code not cleared");
  a_active_copy: assert property (p_active_copy) else $error("spread status wrong");
  c_four_phase: cover property (sel_ff[1:0] == 2'h2 && O_PHASE_OUT_D);
  c_div10: cover property (sel_ff == 4'h4 && $rose(O_PHASE_OUT_A));
  c_spread_on: cover property (O_SPREAD_ACTIVE && O_SPREAD_CODE != 7'h00);
endmodule // mcd_multiphase_divider_properties

// ==== testbench/test_mcd_multiphase_divider.sv ====
/*
  Self-checking bench for the multiphase divider with a clocked load on its outputs.
  Assumes the package and design are compiled first; the spread step is shortened.
*/
`timescale 1ns/1ps

module test_mcd_multiphase_divider;
  localparam int STEP_P = 8;
  logic                   I_CLOCK, I_RST, I_SPREAD_CONTROL, load_clear;
  logic [1:0]             I_DIVIDE_SELECT, I_PHASE_SELECT;
  wire mcd_pkg::mcd_phase_type phases;
  logic [6:0]             O_SPREAD_CODE;
  logic                   O_SPREAD_ACTIVE;
  logic [15:0]            per, hi_a, lag_b, hi_d;
  int                     failures, checks_done;

  mcd_multiphase_divider #(.SPREAD_STEP_CYCLES(STEP_P)) mcd_multiphase_divider_inst (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_DIVIDE_SELECT(I_DIVIDE_SELECT),
    .I_PHASE_SELECT(I_PHASE_SELECT), .I_SPREAD_CONTROL(I_SPREAD_CONTROL),
    .O_PHASE_OUT_A(phases.a), .O_PHASE_OUT_B(phases.b), .O_PHASE_OUT_C(phases.c),
    .O_PHASE_OUT_D(phases.d), .O_SPREAD_CODE(O_SPREAD_CODE), .O_SPREAD_ACTIVE(O_SPREAD_ACTIVE));
  mcd_load_model mcd_load_model_inst (.i_clock(I_CLOCK), .i_clear(load_clear), .i_phase(phases),
    .o_period(per), .o_high_a(hi_a), .o_lag_b(lag_b), .o_high_d(hi_d));

  initial begin
    I_CLOCK = 1'b0;
    forever #10 I_CLOCK = ~I_CLOCK;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge I_CLOCK);
    #2;
  endtask
  task automatic cmp_count(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_value(input logic [6:0] got, input logic [6:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Figures are in steps of half a divided master period, scaled by the divide factor n.
  task automatic run_mode(input logic [1:0] dv, input logic [1:0] psel, input logic [15:0] n,
                          input logic [15:0] per_s, input logic [15:0] hi_s,
                          input logic [15:0] lag_s, input logic [15:0] hid_s);
    I_DIVIDE_SELECT = dv;
    I_PHASE_SELECT = psel;
    step(4 * n * per_s);
    load_clear = 1'b1;
    step(1);
    load_clear = 1'b0;
    step(3 * n * per_s);
    cmp_count(per, n * per_s);
    cmp_count(hi_a, n * hi_s);
    cmp_count(lag_b, n * lag_s);
    cmp_count(hi_d, n * hid_s);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic check_divider;
    run_mode(2'h0, 2'h0, 16'h1, 16'h2, 16'h1, 16'h1, 16'h1);
    run_mode(2'h1, 2'h0, 16'ha, 16'h2, 16'h1, 16'h1, 16'h1);
    run_mode(2'h3, 2'h0, 16'ha, 16'h2, 16'h1, 16'h1, 16'h1);
    run_mode(2'h2, 2'h0, 16'h64, 16'h2, 16'h1, 16'h1, 16'h1);
  endtask
  task automatic check_phases;
    run_mode(2'h0, 2'h1, 16'h1, 16'h6, 16'h2, 16'h2, 16'h0);
    run_mode(2'h1, 2'h3, 16'ha, 16'h6, 16'h2, 16'h2, 16'h0);
    run_mode(2'h0, 2'h2, 16'h1, 16'h8, 16'h4, 16'h2, 16'h4);
    run_mode(2'h2, 2'h2, 16'h64, 16'h8, 16'h4, 16'h2, 16'h4);
  endtask
  task automatic check_spread;
    logic [8:0] lfsr;
    int         wait_cnt;
    lfsr = 9'h000;
    wait_cnt = 0;
    I_SPREAD_CONTROL = 1'b1;
    while (O_SPREAD_CODE === 7'h00 && wait_cnt < 4 * STEP_P) begin
      step(1);
      wait_cnt++;
    end
    for (int k = 0; k < 6; k++) begin
      lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4] ^ (lfsr[7:0] == 8'h00)};
      cmp_value(O_SPREAD_CODE, lfsr[6:0]);
      cmp_value({6'h0, O_SPREAD_ACTIVE}, 7'h01);
      step(STEP_P);
    end
    // The sequence must come back to its first state after 512 steps.
    step(STEP_P * 506);
    cmp_value(O_SPREAD_CODE, 7'h01);
    I_SPREAD_CONTROL = 1'b0;
    step(2);
    cmp_value(O_SPREAD_CODE, 7'h00);
    cmp_value({6'h0, O_SPREAD_ACTIVE}, 7'h00);
  endtask
  task automatic check_reset;
    I_DIVIDE_SELECT = 2'h0;
    I_PHASE_SELECT = 2'h2;
    I_SPREAD_CONTROL = 1'b1;
    I_RST = 1'b1;
    step(2);
    cmp_value({3'h0, phases}, 7'h00);
    cmp_value(O_SPREAD_CODE, 7'h00);
    I_RST = 1'b0;
    step(1);
    cmp_value({3'h0, phases}, 7'h09);
  endtask
  task automatic summarize;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    I_RST = 1'b1;
    I_DIVIDE_SELECT = 2'h0;
    I_PHASE_SELECT = 2'h0;
    load_clear = 1'b0;
    I_SPREAD_CONTROL = 1'b0;
    step(5);
    cmp_value({3'h0, phases}, 7'h00);
    I_RST = 1'b0;
    check_divider();
    check_phases();
    check_spread();
    check_reset();
    summarize();
  end
  // The planned run is near 12000 clocks, so this limit only cuts a hang.
  initial begin
    repeat (30000) @(posedge I_CLOCK);
    failures++;
    summarize();
  end
endmodule // test_mcd_multiphase_divider

bind mcd_multiphase_divider mcd_multiphase_divider_properties #(
  .SPREAD_STEP_CYCLES(SPREAD_STEP_CYCLES)
) mcd_multiphase_divider_properties_inst (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_DIVIDE_SELECT(I_DIVIDE_SELECT),
  .I_PHASE_SELECT(I_PHASE_SELECT), .I_SPREAD_CONTROL(I_SPREAD_CONTROL),
  .O_PHASE_OUT_A(O_PHASE_OUT_A), .O_PHASE_OUT_B(O_PHASE_OUT_B), .O_PHASE_OUT_C(O_PHASE_OUT_C),
  .O_PHASE_OUT_D(O_PHASE_OUT_D), .O_SPREAD_CODE(O_SPREAD_CODE), .O_SPREAD_ACTIVE(O_SPREAD_ACTIVE));
